// File: ptcs_pkg.sv
/*
   ptcs_pkg: register map, field positions, reset values and divider table of the
   programmable timer count-clock block.
   assumes: nibble-wide register port, one aligned nibble per byte address.
*/
package ptcs_pkg;

   // widths
   localparam int NUM_TIMERS = 4;
   localparam int NUM_PAIRS = 2;
   localparam int NIB_W = 4;
   localparam int CNT_W = 8;
   localparam int ADDR_W = 16;
   localparam int DIV_TAPS = 9;
   localparam int EXP_W = 4;

   // count clock selector registers, one per timer at consecutive addresses
   localparam logic [ADDR_W-1:0] TIMER0_CLOCK_SELECT = 16'hFF18;
   localparam logic [ADDR_W-1:0] TIMER1_CLOCK_SELECT = 16'hFF19;
   localparam logic [ADDR_W-1:0] TIMER2_CLOCK_SELECT = 16'hFF1A;
   localparam logic [ADDR_W-1:0] TIMER3_CLOCK_SELECT = 16'hFF1B;

   // timer pair windows: pair 0 (timers 0/1) and pair 1 (timers 2/3)
   localparam logic [ADDR_W-1:0] PAIR_WINDOW_BASE = 16'hFF80;
   localparam int PAIR_WIN_LSB = 5;
   localparam int PAIR_SEL_BIT = 4;
   localparam int SUB_W = 4;
   localparam int SEL_IDX_W = 2;

   // sub-offsets inside a pair window
   localparam logic [SUB_W-1:0] SUB_MODE_CTRL = 4'h0;
   localparam logic [SUB_W-1:0] SUB_RUN_CTRL = 4'h2;
   localparam logic [1:0] REGION_RELOAD = 2'h1;
   localparam logic [1:0] REGION_COUNT = 2'h2;
   localparam logic [1:0] REGION_COMPARE = 2'h3;

   // printed offsets of the timer 2/3 data registers
   localparam logic [ADDR_W-1:0] TIMER3_RELOAD_LOW = 16'hFF96;
   localparam logic [ADDR_W-1:0] TIMER3_RELOAD_HIGH = 16'hFF97;
   localparam logic [ADDR_W-1:0] TIMER2_COUNT_LOW = 16'hFF98;
   localparam logic [ADDR_W-1:0] TIMER2_COUNT_HIGH = 16'hFF99;
   localparam logic [ADDR_W-1:0] TIMER3_COUNT_LOW = 16'hFF9A;
   localparam logic [ADDR_W-1:0] TIMER3_COUNT_HIGH = 16'hFF9B;
   localparam logic [ADDR_W-1:0] TIMER2_COMPARE_LOW = 16'hFF9C;
   localparam logic [ADDR_W-1:0] TIMER2_COMPARE_HIGH = 16'hFF9D;
   localparam logic [ADDR_W-1:0] TIMER3_COMPARE_LOW = 16'hFF9E;
   localparam logic [ADDR_W-1:0] TIMER3_COMPARE_HIGH = 16'hFF9F;

   // mode control fields
   localparam int POLARITY_BIT = 0;
   localparam int NOISE_BIT = 1;
   localparam int EVENT_MODE_BIT = 2;
   localparam int WIDE_MODE_BIT = 3;

   // run control fields: lower timer in bits 1:0, upper timer in bits 3:2
   localparam int RUN_LO_BIT = 0;
   localparam int TRIG_LO_BIT = 1;
   localparam int RUN_HI_BIT = 2;
   localparam int TRIG_HI_BIT = 3;

   // selector encoding
   localparam logic [NIB_W-1:0] SEL_OFF = 4'h0;
   localparam int SEL_HS_BIT = 3;

   // divider exponent per selector code (code 0 unused: clock off)
   localparam logic [EXP_W-1:0] SEL_DIV_EXP [16] = '{
      4'h0, 4'h8, 4'h6, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0,
      4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0
   };

   // reset values
   localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

endpackage

// File: ptcs_prescaler.sv
/*
   ptcs_prescaler: synchronises one oscillator pin into core_clk and turns its
   rising edges into single-cycle ticks divided by 1, 2, 4 ... 256.
   assumes: the oscillator runs below half of core_clk.
*/
`timescale 1ns/1ns
module ptcs_prescaler
   import ptcs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // oscillator pin
   input wire logic oscPin,
   // divided ticks, bit k pulses once per 2**k oscillator periods
   output logic [DIV_TAPS-1:0] divTick
);

   logic syncA_q;
   logic syncB_q;
   logic prev_q;
   logic [CNT_W-1:0] divCnt_q;
   wire oscRise = syncB_q & ~prev_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_q <= 1'b0;
         syncB_q <= 1'b0;
         prev_q <= 1'b0;
         divCnt_q <= CNT_RESET;
      end else begin
         syncA_q <= oscPin;
         syncB_q <= syncA_q;
         prev_q <= syncB_q;
         if (oscRise) begin
            divCnt_q <= divCnt_q + CNT_ONE;
         end
      end
   end

   // ticks are one-cycle pulses of a free-running counter, so switching taps never glitches
   genvar k;
   generate
      for (k = 0; k < DIV_TAPS; k++) begin : g_tap
         localparam logic [CNT_W-1:0] MASK = CNT_W'((1 << k) - 1);
         assign divTick[k] = oscRise & ((divCnt_q & MASK) == MASK);
      end
   endgenerate

endmodule // ptcs_prescaler

// File: ptcs_timer_unit.sv
/*
   ptcs_timer_unit: four 8-bit down-counters with per-timer count clock selection,
   event counting with edge polarity, chained 16-bit pairs and a nibble register port.
   assumes: oscillator and event pins are asynchronous; the register port is on core_clk.
*/
// The strobed register port was left to the implementer.
//
// Operation
// - codes F..8 give high-speed oscillator divided by 1,2,4,8,16,32,64,256.
// - codes 7..1 give low-speed oscillator divided by 1,2,4,16,32,64,256.
// - code 0 stops the count clock; reset clears every selector to 0.
// - each timer owns a 4-bit selector at consecutive addresses.
// - polarity 1 counts rising event edges, 0 counts falling edges.
// - polarity matters only in event counter mode.
// - reset clears both polarity bits.
// - timer 2/3 counts read-only as low then high nibble, zero after reset.
// - timer 2/3 compare values read/write as nibbles, zero after reset.
// - timer 3 reload value read/write as nibbles, zero after reset.
// - reload trigger bits act on write and read back as zero.
// - in event mode timers 0 and 2 count their own event pins.
// - in chained mode the upper timer counts lower timer underflows.
`timescale 1ns/1ns
module ptcs_timer_unit
   import ptcs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // oscillator pins
   input wire logic high_speed_osc_clock,
   input wire logic low_speed_osc_clock,
   // event pins, pair 0 and pair 1
   input wire logic event_input_a,
   input wire logic event_input_b,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [NIB_W-1:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [NIB_W-1:0] regRdData_q,
   // underflow pulses, one per timer
   output logic [NUM_TIMERS-1:0] timerUnderflow_q
);

   // register state
   logic [NUM_TIMERS-1:0][NIB_W-1:0] count_clock_selector_q;
   logic [NUM_TIMERS-1:0][CNT_W-1:0] reloadValue_q;
   logic [NUM_TIMERS-1:0][CNT_W-1:0] compareValue_q;
   logic [NUM_TIMERS-1:0][CNT_W-1:0] countValue_q;
   logic [NUM_TIMERS-1:0] runEnable_q;
   logic [NUM_PAIRS-1:0] eventEdgePolarity_q;
   logic [NUM_PAIRS-1:0] noiseFilterSel_q;
   logic [NUM_PAIRS-1:0] event_count_mode_select_q;
   logic [NUM_PAIRS-1:0] chained_wide_mode_select_q;

   // event pin synchronisers and edge history
   logic [NUM_PAIRS-1:0] evSyncA_q;
   logic [NUM_PAIRS-1:0] evSyncB_q;
   logic [NUM_PAIRS-1:0] evPrev_q;
   logic [NUM_PAIRS-1:0] evEdge;

   // divided oscillator ticks
   logic [DIV_TAPS-1:0] hsTick;
   logic [DIV_TAPS-1:0] lsTick;

   // per-timer internals
   logic [NUM_TIMERS-1:0] underflow;
   logic [NUM_TIMERS-1:0] trigPulse;

   ptcs_prescaler u_hs_prescaler (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .oscPin(high_speed_osc_clock),
      .divTick(hsTick)
   );

   ptcs_prescaler u_ls_prescaler (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .oscPin(low_speed_osc_clock),
      .divTick(lsTick)
   );

   // address decode
   wire selectorHit = (regAddr[ADDR_W-1:SEL_IDX_W] == TIMER0_CLOCK_SELECT[ADDR_W-1:SEL_IDX_W]);
   wire [SEL_IDX_W-1:0] selectorIdx = regAddr[SEL_IDX_W-1:0];
   wire pairHit = (regAddr[ADDR_W-1:PAIR_WIN_LSB] == PAIR_WINDOW_BASE[ADDR_W-1:PAIR_WIN_LSB]);
   wire pairIdx = regAddr[PAIR_SEL_BIT];
   wire [SUB_W-1:0] subAddr = regAddr[SUB_W-1:0];
   wire [1:0] region = subAddr[SUB_W-1:SUB_W-2];
   wire upperSel = subAddr[1];
   wire highNib = subAddr[0];
   wire modeHit = pairHit && (subAddr == SUB_MODE_CTRL);
   wire runHit = pairHit && (subAddr == SUB_RUN_CTRL);
   wire reloadHit = pairHit && (region == REGION_RELOAD);
   wire countHit = pairHit && (region == REGION_COUNT);
   wire compareHit = pairHit && (region == REGION_COMPARE);
   wire [1:0] dataTimer = {pairIdx, upperSel};

   // read selection
   wire [NIB_W-1:0] modeRead = {chained_wide_mode_select_q[pairIdx], event_count_mode_select_q[pairIdx],
                                noiseFilterSel_q[pairIdx], eventEdgePolarity_q[pairIdx]};
   // trigger bits sit at zero in the read word
   wire [NIB_W-1:0] runRead = {1'b0, runEnable_q[{pairIdx, 1'b1}], 1'b0, runEnable_q[{pairIdx, 1'b0}]};
   wire [CNT_W-1:0] reloadWord = reloadValue_q[dataTimer];
   wire [CNT_W-1:0] countWord = countValue_q[dataTimer];
   wire [CNT_W-1:0] compareWord = compareValue_q[dataTimer];
   wire [NIB_W-1:0] reloadNib = highNib ? reloadWord[CNT_W-1:NIB_W] : reloadWord[NIB_W-1:0];
   wire [NIB_W-1:0] countNib = highNib ? countWord[CNT_W-1:NIB_W] : countWord[NIB_W-1:0];
   wire [NIB_W-1:0] compareNib = highNib ? compareWord[CNT_W-1:NIB_W] : compareWord[NIB_W-1:0];
   // unmapped addresses read as zero
   wire [NIB_W-1:0] readMux = selectorHit ? count_clock_selector_q[selectorIdx] :
                              modeHit ? modeRead :
                              runHit ? runRead :
                              reloadHit ? reloadNib :
                              countHit ? countNib :
                              compareHit ? compareNib : NIB_RESET;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData_q <= NIB_RESET;
      end else begin
         regRdData_q <= regRdStrobe ? readMux : NIB_RESET;
      end
   end

   // per-pair mode control and event edge detection
   genvar p;
   generate
      for (p = 0; p < NUM_PAIRS; p++) begin : g_pair
         wire modeWr = regWrStrobe && modeHit && (pairIdx == 1'(p));
         wire evPin = (p == 0) ? event_input_a : event_input_b;

         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               eventEdgePolarity_q[p] <= 1'b0;
               noiseFilterSel_q[p] <= 1'b0;
               event_count_mode_select_q[p] <= 1'b0;
               chained_wide_mode_select_q[p] <= 1'b0;
               evSyncA_q[p] <= 1'b0;
               evSyncB_q[p] <= 1'b0;
               evPrev_q[p] <= 1'b0;
            end else begin
               if (modeWr) begin
                  eventEdgePolarity_q[p] <= regWrData[POLARITY_BIT];
                  noiseFilterSel_q[p] <= regWrData[NOISE_BIT];
                  event_count_mode_select_q[p] <= regWrData[EVENT_MODE_BIT];
                  chained_wide_mode_select_q[p] <= regWrData[WIDE_MODE_BIT];
               end
               evSyncA_q[p] <= evPin;
               evSyncB_q[p] <= evSyncA_q[p];
               evPrev_q[p] <= evSyncB_q[p];
            end
         end

         // polarity picks the edge; it is read only on the event path below
         assign evEdge[p] = eventEdgePolarity_q[p] ? (evSyncB_q[p] & ~evPrev_q[p]) :
                                                     (~evSyncB_q[p] & evPrev_q[p]);
      end
   endgenerate

   // per-timer selector, data registers and down-counter
   genvar t;
   generate
      for (t = 0; t < NUM_TIMERS; t++) begin : g_timer
         localparam int PAIR = t / 2;
         localparam bit UPPER = (t % 2) == 1;
         localparam int RUN_BIT = UPPER ? RUN_HI_BIT : RUN_LO_BIT;
         localparam int TRIG_BIT = UPPER ? TRIG_HI_BIT : TRIG_LO_BIT;

         wire myData = (dataTimer == 2'(t));
         wire selWr = regWrStrobe && selectorHit && (selectorIdx == 2'(t));
         wire runWr = regWrStrobe && runHit && (pairIdx == 1'(PAIR));
         wire reloadWr = regWrStrobe && reloadHit && myData;
         wire compareWr = regWrStrobe && compareHit && myData;

         // selector code to tick: the top bit picks the oscillator, the table the tap
         wire [NIB_W-1:0] code = count_clock_selector_q[t];
         wire [EXP_W-1:0] divExp = SEL_DIV_EXP[code];
         wire hsPick = hsTick[divExp];
         wire lsPick = lsTick[divExp];
         wire selTick = (code != SEL_OFF) && (code[SEL_HS_BIT] ? hsPick : lsPick);
         wire chained = UPPER && chained_wide_mode_select_q[PAIR];
         // only the lower timer of each pair has an event pin
         wire evMode = !UPPER && event_count_mode_select_q[PAIR];
         wire countTick;
         wire running;

         if (UPPER) begin : g_upper
            assign countTick = chained ? underflow[t-1] : selTick;
            // chained pair follows the lower timer's run control
            assign running = chained ? runEnable_q[t-1] : runEnable_q[t];
         end else begin : g_lower
            assign countTick = evMode ? evEdge[PAIR] : selTick;
            assign running = runEnable_q[t];
         end

         assign trigPulse[t] = runWr && regWrData[TRIG_BIT];
         wire step = running && countTick;
         assign underflow[t] = step && (countValue_q[t] == CNT_ZERO);

         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               count_clock_selector_q[t] <= SEL_OFF;
               runEnable_q[t] <= 1'b0;
               reloadValue_q[t] <= CNT_RESET;
               compareValue_q[t] <= CNT_RESET;
               countValue_q[t] <= CNT_RESET;
               timerUnderflow_q[t] <= 1'b0;
            end else begin
               if (selWr) begin
                  count_clock_selector_q[t] <= regWrData;
               end
               if (runWr) begin
                  runEnable_q[t] <= regWrData[RUN_BIT];
               end
               if (reloadWr && highNib) begin
                  reloadValue_q[t][CNT_W-1:NIB_W] <= regWrData;
               end
               if (reloadWr && !highNib) begin
                  reloadValue_q[t][NIB_W-1:0] <= regWrData;
               end
               if (compareWr && highNib) begin
                  compareValue_q[t][CNT_W-1:NIB_W] <= regWrData;
               end
               if (compareWr && !highNib) begin
                  compareValue_q[t][NIB_W-1:0] <= regWrData;
               end
               // software trigger wins over a tick in the same cycle
               if (trigPulse[t]) begin
                  countValue_q[t] <= reloadValue_q[t];
               end else if (underflow[t]) begin
                  countValue_q[t] <= reloadValue_q[t];
               end else if (step) begin
                  countValue_q[t] <= countValue_q[t] - CNT_ONE;
               end
               timerUnderflow_q[t] <= underflow[t];
            end
         end
      end
   endgenerate

endmodule // ptcs_timer_unit

// File: ptcs_props.sv
/*
   ptcs_props: concurrent checks on the register port and underflow pins of the timer unit.
   assumes: bound to ptcs_timer_unit, one core_clk domain, async active-low reset.
*/
`timescale 1ns/1ns
module ptcs_props
   import ptcs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // oscillator and event pins
   input wire logic high_speed_osc_clock,
   input wire logic low_speed_osc_clock,
   input wire logic event_input_a,
   input wire logic event_input_b,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [NIB_W-1:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   input wire logic [NIB_W-1:0] regRdData_q,
   // underflow pulses
   input wire logic [NUM_TIMERS-1:0] timerUnderflow_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // a timer that was never started cannot underflow, whatever its selector says
   logic runSeen_q;
   wire runWrite = regWrStrobe && (regAddr == 16'hFF82 || regAddr == 16'hFF92) && (regWrData[RUN_LO_BIT] || regWrData[RUN_HI_BIT]);
   wire runSeen_d = runSeen_q || runWrite;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         runSeen_q <= 1'b0;
      end else begin
         runSeen_q <= runSeen_d;
      end
   end

   sequence wrRd(lo, hi);
      (regWrStrobe && regAddr >= lo && regAddr <= hi) ##1 (regRdStrobe && regAddr == $past(regAddr));
   endsequence
   property readBack(lo, hi);
      wrRd(lo, hi) |=> regRdData_q == $past(regWrData, 2);
   endproperty

   chk_sel_readback: assert property (readBack(TIMER0_CLOCK_SELECT, TIMER3_CLOCK_SELECT))
      else $error("selector read back differs from written value");
   chk_mode_readback: assert property (readBack(16'hFF90, 16'hFF90))
      else $error("mode register read back differs from written value");
   chk_cmp_readback: assert property (readBack(TIMER2_COMPARE_LOW, TIMER3_COMPARE_HIGH))
      else $error("compare nibble read back differs from written value");
   chk_rld_readback: assert property (readBack(TIMER3_RELOAD_LOW, TIMER3_RELOAD_HIGH))
      else $error("reload nibble read back differs from written value");
   chk_trig_reads_zero: assert property (regRdStrobe && (regAddr == 16'hFF82 || regAddr == 16'hFF92)
      |=> !regRdData_q[TRIG_LO_BIT] && !regRdData_q[TRIG_HI_BIT]) else $error("trigger bit read as one");
   chk_rd_idle_zero: assert property (!regRdStrobe |=> regRdData_q == 4'h0)
      else $error("read data not zero outside a read");
   chk_unmapped_zero: assert property (regRdStrobe && regAddr[15:8] == 8'h00 |=> regRdData_q == 4'h0)
      else $error("unmapped read not zero");
   chk_uflow_gap: assert property (timerUnderflow_q[2] |=> !timerUnderflow_q[2] [*3])
      else $error("underflow pulses closer than any tick allows");
   chk_idle_no_uflow: assert property (!runSeen_q |-> timerUnderflow_q == 4'h0)
      else $error("underflow before any timer was started");
endmodule // ptcs_props

bind ptcs_timer_unit ptcs_props chk (.core_clk(core_clk), .reset_n(reset_n),
   .high_speed_osc_clock(high_speed_osc_clock), .low_speed_osc_clock(low_speed_osc_clock),
   .event_input_a(event_input_a), .event_input_b(event_input_b), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
   .regRdData_q(regRdData_q), .timerUnderflow_q(timerUnderflow_q));

// File: testbench.sv
/*
   testbench: drives the timer unit's pins and register port, scores reads through a queue.
   assumes: ptcs_pkg and ptcs_timer_unit compiled first; 10 MHz core clock.
*/
`timescale 1ns/1ns
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
   import ptcs_pkg::*;
;
   localparam logic [15:0] ADDRS [16] = '{16'hFF18, 16'hFF19, 16'hFF1A, 16'hFF1B, 16'hFF90, 16'hFF92,
      16'hFF96, 16'hFF97, 16'hFF98, 16'hFF99, 16'hFF9A, 16'hFF9B, 16'hFF9C, 16'hFF9D, 16'hFF9E, 16'hFF9F};
   localparam int DIVS [16] = '{0, 256, 64, 32, 16, 4, 2, 1, 256, 64, 32, 16, 8, 4, 2, 1};
   logic core_clk, reset_n, hsOsc, lsOsc, evA, evB, wrStb, rdStb, rdPend;
   logic [ADDR_W-1:0] addr;
   logic [NIB_W-1:0] wrData, rdData;
   logic [NUM_TIMERS-1:0] uflow;
   logic [2:0] oscCnt;
   logic [31:0] lfsr;
   logic [NIB_W-1:0] expQ [$];
   logic [NIB_W-1:0] expHead;
   int errorCnt, comparisons, ufCnt, uf0Cnt, uf1Cnt;

   ptcs_timer_unit uut (.core_clk(core_clk), .reset_n(reset_n), .high_speed_osc_clock(hsOsc),
      .low_speed_osc_clock(lsOsc), .event_input_a(evA), .event_input_b(evB), .regAddr(addr),
      .regWrData(wrData), .regWrStrobe(wrStb), .regRdStrobe(rdStb), .regRdData_q(rdData),
      .timerUnderflow_q(uflow));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // fast oscillator at core/4, slow at core/8: fast keeps two cycles high and low, slow keeps four
   always @(posedge core_clk) begin
      oscCnt <= oscCnt + 3'h1;
      hsOsc <= oscCnt[1];
      lsOsc <= oscCnt[2];
   end

   // read data stand only in the cycle after the strobe, so score them there
   always @(posedge core_clk) begin
      // pop once: the macro evaluates its arguments more than once
      if (rdPend && expQ.size() > 0) begin
         expHead = expQ.pop_front();
         `CHECK(rdData, expHead)
      end
      rdPend <= rdStb;
      if (uflow[0] === 1'b1) uf0Cnt++;
      if (uflow[1] === 1'b1) uf1Cnt++;
      if (uflow[2] === 1'b1) ufCnt++;
   end

   function automatic logic [3:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[3:0];
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [NIB_W-1:0] d);
      @(posedge core_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      rdStb <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [NIB_W-1:0] e);
      @(posedge core_clk);
      addr <= a;
      rdStb <= 1'b1;
      wrStb <= 1'b0;
      expQ.push_back(e);
   endtask

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge core_clk);
         wrStb <= 1'b0;
         rdStb <= 1'b0;
      end
   endtask

   task automatic endTest(input string s);
      idle(3);
      $display("test %s done", s);
   endtask

   task automatic stopTest();
      $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
      if (errorCnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge core_clk);
      errorCnt++;
      stopTest();
   end

   initial begin
      logic [3:0] v;
      int n0, e, per, win;
      reset_n = 1'b0;
      {wrStb, rdStb, rdPend, evA, evB, hsOsc, lsOsc} = 7'h00;
      addr = 16'h0000;
      wrData = 4'h0;
      oscCnt = 3'h0;
      lfsr = 32'h15f8;
      errorCnt = 0;
      comparisons = 0;
      ufCnt = 0;
      uf0Cnt = 0;
      uf1Cnt = 0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (ADDRS[i]) rd(ADDRS[i], 4'h0);
      rd(16'hFF00, 4'h0);
      endTest("reset");
      // counts are read only: a write there must leave zero
      for (int i = 0; i < 16; i++) begin
         if (i != 5) begin
            v = rnd();
            wr(ADDRS[i], v);
            rd(ADDRS[i], (ADDRS[i][15:2] == 14'h3FE6) ? 4'h0 : v);
         end
      end
      endTest("readback");
      wr(16'hFF94, 4'h5);
      wr(16'hFF95, 4'hA);
      wr(16'hFF96, 4'h3);
      wr(16'hFF97, 4'hC);
      wr(16'hFF92, 4'hA);
      rd(16'hFF92, 4'h0);
      rd(16'hFF98, 4'h5);
      rd(16'hFF99, 4'hA);
      rd(16'hFF9A, 4'h3);
      rd(16'hFF9B, 4'hC);
      endTest("reload");
      // m 0: falling edge, m 1: rising edge, m 2: timer mode where pin edges do nothing
      for (int m = 0; m < 3; m++) begin
         wr(16'hFF1A, 4'h0);
         wr(16'hFF90, (m < 2) ? (4'h4 | 4'(m)) : 4'h1);
         wr(16'hFF94, 4'h0);
         wr(16'hFF95, 4'h1);
         wr(16'hFF92, 4'h2);
         wr(16'hFF92, 4'h1);
         idle(4);
         evB <= 1'b1;
         idle(8);
         rd(16'hFF98, (m == 1) ? 4'hF : 4'h0);
         rd(16'hFF99, (m == 1) ? 4'h0 : 4'h1);
         evB <= 1'b0;
         idle(8);
         rd(16'hFF98, (m == 2) ? 4'h0 : 4'hF);
         rd(16'hFF99, (m == 2) ? 4'h1 : 4'h0);
      end
      endTest("event");
      // pair 0 chained: lower counts rising edges of its own pin, upper counts lower underflows
      wr(16'hFF18, 4'h0);
      wr(16'hFF19, 4'h0);
      wr(16'hFF80, 4'hD);
      wr(16'hFF84, 4'h0);
      wr(16'hFF85, 4'h0);
      wr(16'hFF86, 4'h1);
      wr(16'hFF87, 4'h0);
      wr(16'hFF82, 4'hA);
      wr(16'hFF82, 4'h1);
      for (int k = 0; k < 4; k++) begin
         idle(6);
         evA <= 1'b1;
         idle(6);
         evA <= 1'b0;
      end
      idle(8);
      `CHECK(uf0Cnt, 4)
      `CHECK(uf1Cnt, 2)
      rd(16'hFF8A, 4'h1);
      endTest("chain");
      // reload zero makes every tick an underflow, so pulses count ticks
      wr(16'hFF90, 4'h0);
      wr(16'hFF94, 4'h0);
      wr(16'hFF95, 4'h0);
      wr(16'hFF1A, 4'hF);
      wr(16'hFF92, 4'h2);
      wr(16'hFF92, 4'h1);
      for (int c = 15; c >= 0; c--) begin
         per = (c >= 8) ? 4 : 8;
         win = 512 * per;
         e = (c == 0) ? 0 : win / (per * DIVS[c]);
         wr(16'hFF1A, 4'(c));
         idle(20);
         n0 = ufCnt;
         idle(win);
         n0 = ufCnt - n0;
         `CHECK(n0 >= e - 1 && n0 <= e + 1 && (c != 0 || n0 == 0), 1'b1)
      end
      endTest("divider");
      stopTest();
   end
endmodule // testbench
